// ### include/rsc_pkg.sv
// constants and types for the reset source controller
// Behaviour
// (RULE1) filtered low reset pin raises system reset
// (RULE2) pin reset sets external-reset flag
// (RULE3) soft reset instruction resets, clock kept
// (RULE4) soft reset releases next instruction cycle
// (RULE5) soft reset sets flag bit 6
// (RULE6) watchdog timeout in run resets, clock kept
// (RULE7) watchdog timeout in sleep/idle only wakes
// (RULE8) watchdog reset sets flag bit 4
// (RULE9) lower hard trap during higher trap resets
// (RULE10) levels 13 to 15 are hard traps
// (RULE11) trap conflict reset sets flag bit 15
// (RULE12) flag register value depends on reset kind
// (RULE13) flags survive resets, cleared by write/power-on
package rsc_pkg;

    localparam int RCR_W = 16;
    localparam int TRAP_BIT = 15;
    localparam int EXT_BIT = 7;
    localparam int SOFT_BIT = 6;
    localparam int WDT_BIT = 4;
    localparam logic [15:0] RCR_RESET = 16'h0000;
    localparam logic [15:0] RCR_FLAG_MASK = 16'h80d0;

    localparam int LVL_W = 4;
    localparam logic [3:0] HARD_LO_LVL = 4'hd;
    localparam logic [3:0] ADDR_ERR_LVL = 4'hd;
    localparam logic [3:0] OSC_ERR_LVL = 4'he;
    localparam logic [3:0] HARD_HI_LVL = 4'hf;

    localparam int CLK_PERIOD_NS = 4;
    // shortest pin low time that counts as a reset
    localparam int EXT_MIN_NS = 2000;
    localparam int EXT_MIN_CYC =
        (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // soft, watchdog and trap resets last one instruction cycle
    localparam int PULSE_CYC = 1;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_PULSE = 3'b010,
        ST_EXT = 3'b100
    } rsc_state_e;

    function automatic logic rsc_is_hard(input logic [3:0] lvl);
        rsc_is_hard = (lvl >= HARD_LO_LVL) && (lvl <= HARD_HI_LVL);
    endfunction : rsc_is_hard

endpackage : rsc_pkg

// ### core/rsc_reset_source.sv
// reset source controller: pin filter, reset sequencing, cause flags
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_source
    import rsc_pkg::*;
#(
    parameter int FILT_CYC = EXT_MIN_CYC,
    parameter int HOLD_CYC = PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_reset_pin_n,
    input wire logic soft_reset_exec,
    input wire logic watchdog_timeout,
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    input wire logic trap_req,
    input wire logic [3:0] trap_level,
    input wire logic trap_done,
    input wire logic rcr_wr_en,
    input wire logic [15:0] rcr_wr_data,
    output logic system_reset,
    output logic clock_reinit,
    output logic wake_req,
    output logic [15:0] reset_control_reg
);

    localparam int FILT_W = $clog2(FILT_CYC + 1);
    localparam int HOLD_W = $clog2(HOLD_CYC + 1);
    localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(FILT_CYC);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC - 1);

    if (FILT_CYC < 1 || HOLD_CYC < 1) begin : g_bad_param
        $error("filter and hold counts must be at least one");
    end

    ////////////////////////////////////////////////////////////////
    // pin synchroniser and glitch filter

    logic pin_s1_q;
    logic pin_s2_q;
    logic [FILT_W-1:0] filt_cnt_q;
    logic [FILT_W-1:0] filt_cnt_d;
    logic ext_low_q;
    logic ext_low_d;

    always_comb begin
        filt_cnt_d = filt_cnt_q;
        ext_low_d = ext_low_q;
        if (pin_s2_q) begin
            filt_cnt_d = '0;
            ext_low_d = 1'b0;
        end else if (filt_cnt_q < FILT_MAX) begin
            // short pulses never reach the limit
            filt_cnt_d = filt_cnt_q + FILT_W'(1); // RULE1
            ext_low_d = (filt_cnt_d == FILT_MAX); // RULE1
        end else begin
            ext_low_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            filt_cnt_q <= '0;
            ext_low_q <= 1'b0;
        end else begin
            pin_s1_q <= ext_reset_pin_n;
            pin_s2_q <= pin_s1_q;
            filt_cnt_q <= filt_cnt_d;
            ext_low_q <= ext_low_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // hard trap tracking

    rsc_state_e state_q;
    rsc_state_e state_d;
    logic trap_act_q;
    logic trap_act_d;
    logic [3:0] trap_lvl_q;
    logic [3:0] trap_lvl_d;
    logic hard_req;
    logic conflict;

    assign hard_req = trap_req && rsc_is_hard(trap_level); // RULE10
    // a lower level arriving while a hard trap is open
    assign conflict = hard_req && trap_act_q
        && (trap_level < trap_lvl_q); // RULE9

    always_comb begin
        trap_act_d = trap_act_q;
        trap_lvl_d = trap_lvl_q;
        if (state_q != ST_RUN) begin
            trap_act_d = 1'b0;
        end else begin
            if (trap_done) begin
                trap_act_d = 1'b0;
            end
            if (hard_req && !conflict) begin
                trap_act_d = 1'b1;
                trap_lvl_d = trap_level;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_act_q <= 1'b0;
            trap_lvl_q <= 4'h0;
        end else begin
            trap_act_q <= trap_act_d;
            trap_lvl_q <= trap_lvl_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // reset sequencer

    logic [HOLD_W-1:0] hold_q;
    logic [HOLD_W-1:0] hold_d;
    logic lowpow;
    logic ev_soft;
    logic ev_wdt;
    logic ev_trap;
    logic ev_ext;
    logic wake_d;
    logic system_reset_d;
    logic reinit_d;

    assign lowpow = cpu_sleep || cpu_idle;
    // soft, watchdog and trap causes are taken only while running; the pin also during a pulse
    assign ev_soft = (state_q == ST_RUN) && soft_reset_exec; // RULE3
    assign ev_wdt = (state_q == ST_RUN) && watchdog_timeout
        && !lowpow; // RULE6
    assign ev_trap = (state_q == ST_RUN) && conflict; // RULE9
    assign ev_ext = (state_q != ST_EXT) && ext_low_q; // RULE1

    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        case (state_q)
            ST_RUN: begin
                if (ext_low_q) begin
                    state_d = ST_EXT;
                end else if (ev_soft || ev_wdt || ev_trap) begin
                    state_d = ST_PULSE;
                    hold_d = HOLD_LOAD;
                end
            end
            ST_PULSE: begin
                if (ext_low_q) begin
                    state_d = ST_EXT;
                end else if (hold_q == '0) begin
                    // release at the next instruction cycle
                    state_d = ST_RUN; // RULE4
                end else begin
                    hold_d = hold_q - HOLD_W'(1);
                end
            end
            ST_EXT: begin
                if (!ext_low_q) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_EXT;
            end
        endcase
        system_reset_d = (state_d != ST_RUN);
        // only the pin reset and power-on restart the clock source
        reinit_d = (state_d == ST_EXT); // RULE3 RULE6
        wake_d = (state_q == ST_RUN) && watchdog_timeout
            && lowpow; // RULE7
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            hold_q <= '0;
            system_reset <= 1'b1;
            clock_reinit <= 1'b1;
            wake_req <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            system_reset <= system_reset_d;
            clock_reinit <= reinit_d;
            wake_req <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // reset cause flags

    logic [15:0] rcr_d;

    always_comb begin
        rcr_d = reset_control_reg;
        // software write clears or sets the flags
        if (rcr_wr_en) begin
            rcr_d = rcr_wr_data & RCR_FLAG_MASK; // RULE13
        end
        // a cause in the write cycle still sets its flag
        if (ev_ext) begin
            rcr_d[EXT_BIT] = 1'b1; // RULE2 RULE12
        end
        if (ev_soft) begin
            rcr_d[SOFT_BIT] = 1'b1; // RULE5 RULE12
        end
        if (ev_wdt) begin
            rcr_d[WDT_BIT] = 1'b1; // RULE8 RULE12
        end
        if (ev_trap) begin
            rcr_d[TRAP_BIT] = 1'b1; // RULE11 RULE12
        end
    end

    // only power-on or a software write clears these; system_reset never does
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_control_reg <= RCR_RESET; // RULE13
        end else begin
            reset_control_reg <= rcr_d;
        end
    end

endmodule : rsc_reset_source
`default_nettype wire

// ### bench/rsc_chk.sv
// assertions on the reset source ports
`timescale 1ns/10ps
`default_nettype none
module rsc_chk
    import rsc_pkg::*;
#(
    parameter int FILT_CYC = EXT_MIN_CYC,
    parameter int HOLD_CYC = PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_reset_pin_n,
    input wire logic soft_reset_exec,
    input wire logic watchdog_timeout,
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    input wire logic trap_req,
    input wire logic [3:0] trap_level,
    input wire logic trap_done,
    input wire logic rcr_wr_en,
    input wire logic [15:0] rcr_wr_data,
    input wire logic system_reset,
    input wire logic clock_reinit,
    input wire logic wake_req,
    input wire logic [15:0] reset_control_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    soft_rst_a: assert property (soft_reset_exec && !system_reset |=>
        system_reset && reset_control_reg[SOFT_BIT] && !clock_reinit)
        else $error("soft reset missing");
    soft_rel_a: assert property ($rose(system_reset) && !clock_reinit
        |=> !system_reset) else $error("reset pulse too long");
    wdt_run_a: assert property (watchdog_timeout && !cpu_sleep
        && !cpu_idle && !system_reset |=> system_reset)
        else $error("watchdog reset missing");
    wdt_flag_a: assert property ($rose(system_reset)
        && $past(watchdog_timeout) |-> reset_control_reg[WDT_BIT])
        else $error("watchdog flag missing");
    wake_only_a: assert property (watchdog_timeout && (cpu_sleep ||
        cpu_idle) && !system_reset && !soft_reset_exec && !trap_req
        |=> wake_req && !system_reset) else $error("wake wrong");
    ext_flag_a: assert property ($rose(clock_reinit) |->
        system_reset && reset_control_reg[EXT_BIT])
        else $error("pin flag missing");
    pin_filt_a: assert property ($rose(clock_reinit) |->
        !$past(ext_reset_pin_n, FILT_CYC)) else $error("glitch passed");
    flag_keep_a: assert property (!rcr_wr_en |=>
        (reset_control_reg & $past(reset_control_reg))
        == $past(reset_control_reg)) else $error("flag lost");
endmodule : rsc_chk
bind rsc_reset_source rsc_chk #(.FILT_CYC(FILT_CYC), .HOLD_CYC(HOLD_CYC))
    u_chk (.clk, .rst_n, .ext_reset_pin_n, .soft_reset_exec,
    .watchdog_timeout, .cpu_sleep, .cpu_idle, .trap_req, .trap_level,
    .trap_done, .rcr_wr_en, .rcr_wr_data, .system_reset, .clock_reinit,
    .wake_req, .reset_control_reg);
`default_nettype wire

// ### bench/rsc_sup.sv
// supervisory circuit model: holds the reset pin low for len cycles
`timescale 1ns/10ps
`default_nettype none
module rsc_sup (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] len,
    output logic pin_n
);
    logic [7:0] cnt_q = 8'h00;
    always @(posedge clk) begin
        if (go)
            cnt_q <= len;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    assign pin_n = (cnt_q == 8'h00);
endmodule : rsc_sup
`default_nettype wire

// ### bench/rsc_tb.sv
// self-checking bench for the reset source controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, rst_n, soft_reset_exec, watchdog_timeout, cpu_sleep;
    logic cpu_idle, trap_req, trap_done, rcr_wr_en, go, ext_reset_pin_n;
    logic [3:0] trap_level;
    logic [7:0] len;
    logic [15:0] rcr_wr_data, reset_control_reg, o;
    logic system_reset, clock_reinit, wake_req;
    int fail_count = 0;
    int n_checks = 0;
    assign o = {13'h0, system_reset, clock_reinit, wake_req};
    rsc_reset_source #(.FILT_CYC(4), .HOLD_CYC(1)) DUT (.clk, .rst_n,
        .ext_reset_pin_n, .soft_reset_exec, .watchdog_timeout, .cpu_sleep,
        .cpu_idle, .trap_req, .trap_level, .trap_done, .rcr_wr_en,
        .rcr_wr_data, .system_reset, .clock_reinit, .wake_req,
        .reset_control_reg);
    rsc_sup SUP (.clk, .go, .len, .pin_n(ext_reset_pin_n));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : ck
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic wt(input logic v);
        for (int i = 0; i < 80 && system_reset !== v; i++)
            tk(1);
        if (system_reset !== v) begin
            fail_count++;
            end_sim();
        end
    endtask : wt
    task automatic pulse(input logic [7:0] n);
        len = n;
        go = 1'b1;
        tk(1);
        go = 1'b0;
    endtask : pulse
    initial begin
        {rst_n, soft_reset_exec, watchdog_timeout, cpu_sleep} = 4'h0;
        {cpu_idle, trap_req, trap_done, rcr_wr_en, go} = 5'h00;
        trap_level = 4'h0;
        len = 8'h00;
        rcr_wr_data = 16'h0000;
        tk(5);
        rst_n = 1'b1;
        tk(2);
        ck(reset_control_reg, 16'h0000);
        soft_reset_exec = 1'b1;
        tk(1);
        soft_reset_exec = 1'b0;
        ck(o, 16'h0004);
        ck(reset_control_reg, 16'h0040);
        tk(1);
        ck(o, 16'h0000);
        $display("soft reset test done");
        watchdog_timeout = 1'b1;
        tk(1);
        watchdog_timeout = 1'b0;
        ck(o, 16'h0004);
        ck(reset_control_reg, 16'h0050);
        for (int m = 1; m < 3; m++) begin
            tk(1);
            {cpu_sleep, cpu_idle} = 2'(m);
            watchdog_timeout = 1'b1;
            tk(1);
            {cpu_sleep, cpu_idle, watchdog_timeout} = 3'h0;
            ck(o, 16'h0001);
        end
        $display("watchdog test done");
        {trap_req, trap_level} = 5'h1f;
        tk(1);
        trap_level = 4'hc;
        tk(1);
        ck(o, 16'h0000);
        trap_done = 1'b1;
        tk(1);
        {trap_done, trap_level} = 5'h0e;
        tk(1);
        ck(o, 16'h0000);
        trap_level = 4'hf;
        tk(1);
        trap_level = 4'he;
        tk(1);
        trap_req = 1'b0;
        ck(o, 16'h0004);
        ck(reset_control_reg, 16'h8050);
        tk(1);
        $display("trap test done");
        {rcr_wr_en, rcr_wr_data} = 17'h17f2f;
        tk(1);
        rcr_wr_en = 1'b0;
        ck(reset_control_reg, 16'h0000);
        pulse(8'h03);
        repeat (12) begin
            tk(1);
            ck(o, 16'h0000);
        end
        pulse(8'h14);
        wt(1'b1);
        ck(o, 16'h0006);
        ck(reset_control_reg, 16'h0080);
        wt(1'b0);
        $display("pin test done");
        rst_n = 1'b0;
        tk(1);
        ck(o, 16'h0006);
        ck(reset_control_reg, 16'h0000);
        $display("power-on test done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
